// *** hdl/lvdtn_image.sv ***
// Behaviour
// R1: disabled channel and power-up/config words zero
// R2: each channel enabled independently
// R3: alignment places converter value, speed zero
// R4: measurement channel one words 2-4
// R5: measurement channel two words 6-8, 9 reserved
// R6: values as 32-bit sign/magnitude words
// R7: top bit sign, rest absolute value
// R8: module status layout fixed in all modes
// R9: acknowledge bit 15 set on command
// R10: transmit cleared, device clears acknowledge
// R11: no new command while acknowledge set
// R12: heartbeat bit 14 toggles every 50 ms
// R13: bit 13 reports master zero, slave one
// R14: initialized bit 12 set, cleared on command
// R15: bit 11 only in calibration mode
// R16: bit 10 only in configuration mode
// R17: bit 9 only in alignment mode
// R18: bit 8 only in measurement mode
// R19: bits 7 to 4 always zero
// R20: error code in bits 3 to 0
// R21: excitation voltage range 800 to 12000 mV
// R22: mode flags exclusive, exactly one set
module lvdtn_image
    import lvdtn_pkg::*;
#(
    parameter int unsigned BEAT_CYCLES = LVDTN_BEAT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic self_test_done,
    input wire logic powered_up,
    input wire lvdtn_mode_type mode,
    input wire logic is_slave,
    input wire lvdtn_chan_type ch1,
    input wire lvdtn_chan_type ch2,
    input wire lvdtn_cmd_type cmd,
    input wire logic [3:0] rd_index,
    output logic [15:0] rd_word,
    output logic [159:0] image_flat,
    output logic cmd_accept
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // two's complement to sign/magnitude
    function automatic logic [31:0] lvdtn_signmag(input logic signed [31:0] v);
        logic [31:0] mag;
        mag = v[31] ? 32'(-v) : 32'(v);
        // R7: sign on top, magnitude below
        return {v[31], mag[30:0]};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    lvdtn_state_type s_q; // all flops except accept_q
    lvdtn_state_type s_d; // next value
    logic rst_n; // synchronised reset
    logic accept_d; // command taken this cycle
    logic accept_q; // registered accept pulse
    logic [15:0] status_w; // module status word
    logic [15:0] words [LVDTN_WORDS]; // next image words
    logic ch_live [2]; // channel data gated on
    lvdtn_chan_type chs [2]; // channel array

    assign chs[0] = ch1;
    assign chs[1] = ch2;

    // synchronised reset, read only from the second stage
    assign rst_n = s_q.rst_sync[1];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // synchroniser shifts in ones after reset release
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        // R11: refuse commands while acknowledge high
        accept_d = cmd.transmit && !s_q.ack && powered_up;
        // R9: acknowledge set on accepted command
        if (accept_d) begin
            s_d.ack = 1'b1;
        // R10: transmit low clears acknowledge
        end else if (!cmd.transmit) begin
            s_d.ack = 1'b0;
        end
        // R14: set after self test, cleared on first command
        if (accept_d) begin
            s_d.init = 1'b0;
        end else if (self_test_done && !s_q.init && s_q.err == 4'hF) begin
            s_d.init = 1'b1;
        end
        // first-init latch uses err=F as "not yet initialised" marker
        if (s_q.err == 4'hF && self_test_done) begin
            s_d.err = LVDTN_ERR_NONE;
        end
        // R20: error code captured on accepted command
        if (accept_d) begin
            // R21: excitation voltage window
            if (cmd.cmd_bad) begin
                s_d.err = LVDTN_ERR_CMD;
            end else if (cmd.flash_bad) begin
                s_d.err = LVDTN_ERR_FLASH;
            end else if (cmd.exc_mv < LVDTN_EXC_MV_MIN || cmd.exc_mv > LVDTN_EXC_MV_MAX) begin
                s_d.err = LVDTN_ERR_EXC_V;
            end else if (cmd.exc_freq_bad) begin
                s_d.err = LVDTN_ERR_EXC_F;
            end else begin
                s_d.err = LVDTN_ERR_NONE;
            end
        end
        // R12: heartbeat toggles each period
        if (s_q.beat_cnt >= 32'(BEAT_CYCLES - 1)) begin
            s_d.beat_cnt = 32'h0;
            s_d.beat = !s_q.beat;
        end else begin
            s_d.beat_cnt = s_q.beat_cnt + 32'h1;
        end
        // R8: one fixed status layout
        status_w = 16'h0000;
        status_w[LVDTN_BIT_ACK] = s_q.ack;
        status_w[LVDTN_BIT_BEAT] = s_q.beat;
        // R13: excitation role bit
        status_w[LVDTN_BIT_SLAVE] = is_slave;
        status_w[LVDTN_BIT_INIT] = s_q.init;
        // R15 R16 R17 R18 R22: exactly one mode flag
        status_w[LVDTN_BIT_CAL] = (mode == LVDTN_MODE_CAL);
        status_w[LVDTN_BIT_CFG] = (mode == LVDTN_MODE_CFG);
        status_w[LVDTN_BIT_ALN] = (mode == LVDTN_MODE_ALN);
        status_w[LVDTN_BIT_MEAS] = (mode == LVDTN_MODE_MEAS);
        // R19: reserved bits stay zero
        status_w[7:4] = 4'h0;
        status_w[3:0] = (s_q.err == 4'hF) ? LVDTN_ERR_NONE : s_q.err;
        words[LVDTN_OFS_MODULE] = status_w;
        words[LVDTN_OFS_SPARE] = LVDTN_ZERO_WORD;
        // R2: per channel data placement
        for (int c = 0; c < 2; c++) begin
            logic [31:0] v;
            logic [3:0] b;
            v = 32'h0;
            b = (c == 0) ? LVDTN_OFS_CH1_STATE : LVDTN_OFS_CH2_STATE;
            // R1: zero when disabled or not running
            ch_live[c] = chs[c].enabled && powered_up &&
                         (mode == LVDTN_MODE_ALN || mode == LVDTN_MODE_MEAS);
            words[b] = chs[c].state_word;
            // R3: converter value in alignment
            // R4 R5 R6: position as sign/magnitude pair
            if (mode == LVDTN_MODE_ALN) begin
                v = lvdtn_signmag(chs[c].adc_value);
            end else begin
                v = lvdtn_signmag(chs[c].position);
            end
            words[4'(b + 4'h1)] = ch_live[c] ? v[31:16] : LVDTN_ZERO_WORD;
            words[4'(b + 4'h2)] = ch_live[c] ? v[15:0] : LVDTN_ZERO_WORD;
            words[4'(b + 4'h3)] = (ch_live[c] && mode == LVDTN_MODE_MEAS) ?
                                  chs[c].speed : LVDTN_ZERO_WORD;
        end
        for (int w = 0; w < LVDTN_WORDS; w++) begin
            s_d.image[w*16 +: 16] = words[w];
        end
        s_d.word_out = (rd_index < 4'(LVDTN_WORDS)) ?
                       s_q.image[rd_index*16 +: 16] : LVDTN_ZERO_WORD;
        // hold everything but the synchroniser until reset is released
        if (!rst_n) begin
            s_d = s_q;
            s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
            accept_d = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // state flops, async reset straight from the pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.rst_sync <= 2'h0;
            s_q.ack <= 1'b0;
            s_q.beat <= 1'b0;
            s_q.init <= 1'b0;
            // all ones marks a fresh power-on reset
            s_q.err <= 4'hF;
            s_q.beat_cnt <= 32'h0;
            s_q.word_out <= 16'h0000;
            s_q.image <= '0;
            accept_q <= 1'b0;
        end else begin
            // whole state registered from its next value
            s_q <= s_d;
            accept_q <= accept_d;
        end
    end

    assign rd_word = s_q.word_out;
    assign image_flat = s_q.image;
    assign cmd_accept = accept_q;

    // ----------------------------------------------------------------
    // handshake checks
    // ----------------------------------------------------------------
    // R11: refuse while acknowledged
    a_ack_refuse: assert property (@(posedge clk) disable iff (!rst_n) // R11
        s_q.ack |-> !accept_d)
        else $error("command taken while ack high");
    // R9: acknowledge shown
    a_ack_set: assert property (@(posedge clk) disable iff (!rst_n) // R9
        accept_d |=> s_q.image[LVDTN_BIT_ACK] == 1'b0 ##1 s_q.image[LVDTN_BIT_ACK])
        else $error("ack not shown after command");
    // R10: acknowledge cleared
    a_ack_clear: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (s_q.ack && !cmd.transmit) |=> !s_q.ack)
        else $error("ack not cleared");
    // R11: one accept pulse
    a_accept_once: assert property (@(posedge clk) disable iff (!rst_n) // R11
        cmd_accept |=> !cmd_accept)
        else $error("command accepted twice");
    // R14: init cleared
    a_init_clear: assert property (@(posedge clk) disable iff (!rst_n) // R14
        accept_d |=> !s_q.init)
        else $error("init not cleared on command");
    // R21: voltage window
    a_err_range: assert property (@(posedge clk) disable iff (!rst_n) // R21
        (accept_d && !cmd.cmd_bad && !cmd.flash_bad && (cmd.exc_mv < LVDTN_EXC_MV_MIN ||
        cmd.exc_mv > LVDTN_EXC_MV_MAX)) |=> s_q.err == LVDTN_ERR_EXC_V)
        else $error("voltage error not flagged");
    // R20: known error codes
    a_err_code: assert property (@(posedge clk) disable iff (!rst_n) // R20
        s_q.image[3:0] <= LVDTN_ERR_EXC_F)
        else $error("unknown error code");

    // ----------------------------------------------------------------
    // status word checks
    // ----------------------------------------------------------------
    // R12: heartbeat toggle
    a_beat_period: assert property (@(posedge clk) disable iff (!rst_n) // R12
        (s_q.beat_cnt == 32'h0 && $past(s_q.beat_cnt) != 32'h0) |-> $changed(s_q.beat))
        else $error("heartbeat not toggled");
    // R12: counter bound
    a_beat_bound: assert property (@(posedge clk) disable iff (!rst_n) // R12
        s_q.beat_cnt < 32'(BEAT_CYCLES))
        else $error("heartbeat counter overrun");
    // R13: role bit
    a_slave_bit: assert property (@(posedge clk) disable iff (!rst_n) // R13
        1'b1 |=> s_q.image[LVDTN_BIT_SLAVE] == $past(is_slave))
        else $error("role bit wrong");
    // R15: calibration flag
    a_cal_flag: assert property (@(posedge clk) disable iff (!rst_n) // R15
        1'b1 |=> s_q.image[LVDTN_BIT_CAL] == ($past(mode) == LVDTN_MODE_CAL))
        else $error("calibration flag wrong");
    // R16: configuration flag
    a_cfg_flag: assert property (@(posedge clk) disable iff (!rst_n) // R16
        1'b1 |=> s_q.image[LVDTN_BIT_CFG] == ($past(mode) == LVDTN_MODE_CFG))
        else $error("configuration flag wrong");
    // R17: alignment flag
    a_aln_flag: assert property (@(posedge clk) disable iff (!rst_n) // R17
        1'b1 |=> s_q.image[LVDTN_BIT_ALN] == ($past(mode) == LVDTN_MODE_ALN))
        else $error("alignment flag wrong");
    // R18: measurement flag
    a_meas_flag: assert property (@(posedge clk) disable iff (!rst_n) // R18
        1'b1 |=> s_q.image[LVDTN_BIT_MEAS] == ($past(mode) == LVDTN_MODE_MEAS))
        else $error("measurement flag wrong");
    // R22: one mode flag
    a_mode_onehot: assert property (@(posedge clk) disable iff (!rst_n) // R22
        $past(rst_n) |-> $onehot(s_q.image[11:8]))
        else $error("mode flags not one-hot");
    // R19: reserved bits zero
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n) // R19
        s_q.image[7:4] == 4'h0)
        else $error("reserved bits set");

    // ----------------------------------------------------------------
    // channel data checks
    // ----------------------------------------------------------------
    // R1: both channels off
    a_dis_zero: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (!ch1.enabled && !ch2.enabled) |=> s_q.image[159:144] == 16'h0 &&
        s_q.image[63:32] == 32'h0 && s_q.image[143:96] == 48'h0 && s_q.image[79:64] == 16'h0)
        else $error("disabled channel data nonzero");
    // R1: power-up zero
    a_pwr_zero: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !powered_up |=> s_q.image[79:32] == 48'h0 && s_q.image[143:96] == 48'h0)
        else $error("data during power-up");
    // R1: configuration zero
    a_cfg_zero: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (mode == LVDTN_MODE_CFG) |=> s_q.image[79:32] == 48'h0 && s_q.image[143:96] == 48'h0)
        else $error("data in configuration");
    // R2: channel one off
    a_ch1_off: assert property (@(posedge clk) disable iff (!rst_n) // R2
        !ch1.enabled |=> s_q.image[79:32] == 48'h0)
        else $error("channel one data while off");
    // R2: channel two off
    a_ch2_off: assert property (@(posedge clk) disable iff (!rst_n) // R2
        !ch2.enabled |=> s_q.image[143:96] == 48'h0)
        else $error("channel two data while off");
    // R1: state word one
    a_ch1_state: assert property (@(posedge clk) disable iff (!rst_n) // R1
        1'b1 |=> s_q.image[31:16] == $past(ch1.state_word))
        else $error("channel one state word wrong");
    // R1: state word two
    a_ch2_state: assert property (@(posedge clk) disable iff (!rst_n) // R1
        1'b1 |=> s_q.image[95:80] == $past(ch2.state_word))
        else $error("channel two state word wrong");
    // R3: speed one zero
    a_aln_speed: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (mode == LVDTN_MODE_ALN) |=> s_q.image[79:64] == 16'h0)
        else $error("speed in alignment");
    // R3: speed two zero
    a_aln_speed2: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (mode == LVDTN_MODE_ALN) |=> s_q.image[143:128] == 16'h0)
        else $error("speed two in alignment");
    // R3: converter sign shown
    a_aln_sign: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (mode == LVDTN_MODE_ALN && ch1.enabled && powered_up) |=> s_q.image[47] == $past(ch1.adc_value[31]))
        else $error("converter sign wrong");
    // R4: speed one shown
    a_speed1: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (mode == LVDTN_MODE_MEAS && ch1.enabled && powered_up) |=> s_q.image[79:64] == $past(ch1.speed))
        else $error("channel one speed wrong");
    // R5: speed two shown
    a_speed2: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (mode == LVDTN_MODE_MEAS && ch2.enabled && powered_up) |=> s_q.image[143:128] == $past(ch2.speed))
        else $error("channel two speed wrong");
    // R7: position sign bit
    a_sign1: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (mode == LVDTN_MODE_MEAS && ch1.enabled && powered_up) |=> s_q.image[47] == $past(ch1.position[31]))
        else $error("position sign wrong");
    // R5: spare word zero
    a_spare_zero: assert property (@(posedge clk) disable iff (!rst_n) // R5
        s_q.image[159:144] == 16'h0)
        else $error("spare word nonzero");

    // ----------------------------------------------------------------
    // covers
    // ----------------------------------------------------------------
    // full command handshake
    c_cmd_hand: cover property (@(posedge clk) disable iff (!rst_n)
        accept_d ##[1:10] !s_q.ack);
    // heartbeat edge
    c_beat: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(s_q.beat));
    // measurement with one channel
    c_meas: cover property (@(posedge clk) disable iff (!rst_n)
        mode == LVDTN_MODE_MEAS && ch1.enabled && !ch2.enabled);
    // alignment with one channel
    c_align: cover property (@(posedge clk) disable iff (!rst_n)
        mode == LVDTN_MODE_ALN && ch1.enabled && !ch2.enabled && powered_up);
    // held transmit refused
    c_refuse: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.ack && cmd.transmit);
endmodule // lvdtn_image

// *** hdl/lvdtn_pkg.sv ***
package lvdtn_pkg;
    // ----------------------------------------------------------------
    // image layout
    // ----------------------------------------------------------------
    localparam int unsigned LVDTN_WORDS = 10;
    localparam logic [3:0] LVDTN_OFS_MODULE = 4'h0;
    localparam logic [3:0] LVDTN_OFS_CH1_STATE = 4'h1;
    localparam logic [3:0] LVDTN_OFS_CH1_HIGH = 4'h2;
    localparam logic [3:0] LVDTN_OFS_CH1_LOW = 4'h3;
    localparam logic [3:0] LVDTN_OFS_CH1_SPEED = 4'h4;
    localparam logic [3:0] LVDTN_OFS_CH2_STATE = 4'h5;
    localparam logic [3:0] LVDTN_OFS_CH2_HIGH = 4'h6;
    localparam logic [3:0] LVDTN_OFS_CH2_LOW = 4'h7;
    localparam logic [3:0] LVDTN_OFS_CH2_SPEED = 4'h8;
    localparam logic [3:0] LVDTN_OFS_SPARE = 4'h9;
    localparam logic [15:0] LVDTN_ZERO_WORD = 16'h0000;

    // ----------------------------------------------------------------
    // module state word bit positions
    // ----------------------------------------------------------------
    localparam int unsigned LVDTN_BIT_ACK = 15;
    localparam int unsigned LVDTN_BIT_BEAT = 14;
    localparam int unsigned LVDTN_BIT_SLAVE = 13;
    localparam int unsigned LVDTN_BIT_INIT = 12;
    localparam int unsigned LVDTN_BIT_CAL = 11;
    localparam int unsigned LVDTN_BIT_CFG = 10;
    localparam int unsigned LVDTN_BIT_ALN = 9;
    localparam int unsigned LVDTN_BIT_MEAS = 8;

    // ----------------------------------------------------------------
    // error codes
    // ----------------------------------------------------------------
    localparam logic [3:0] LVDTN_ERR_NONE = 4'h0;
    localparam logic [3:0] LVDTN_ERR_CMD = 4'h1;
    localparam logic [3:0] LVDTN_ERR_FLASH = 4'h2;
    localparam logic [3:0] LVDTN_ERR_EXC_V = 4'h3;
    localparam logic [3:0] LVDTN_ERR_EXC_F = 4'h4;
    localparam logic [15:0] LVDTN_EXC_MV_MIN = 16'h0320;
    localparam logic [15:0] LVDTN_EXC_MV_MAX = 16'h2EE0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned LVDTN_CLK_HZ = 50_000_000;
    localparam int unsigned LVDTN_BEAT_MS = 50;
    localparam int unsigned LVDTN_BEAT_CYC = LVDTN_CLK_HZ / 1000 * LVDTN_BEAT_MS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LVDTN_MODE_CAL,
        LVDTN_MODE_CFG,
        LVDTN_MODE_ALN,
        LVDTN_MODE_MEAS
    } lvdtn_mode_type;

    // per-channel sample from the conditioner core
    typedef struct packed {
        logic enabled;
        logic [15:0] state_word;
        logic signed [31:0] adc_value;
        logic signed [31:0] position;
        logic [15:0] speed;
    } lvdtn_chan_type;

    // command word handshake and status inputs
    typedef struct packed {
        logic transmit;
        logic cmd_bad;
        logic flash_bad;
        logic [15:0] exc_mv;
        logic exc_freq_bad;
    } lvdtn_cmd_type;

    // all registered state except the accept pulse
    typedef struct packed {
        logic [1:0] rst_sync;
        logic ack;
        logic beat;
        logic init;
        logic [3:0] err;
        logic [31:0] beat_cnt;
        logic [15:0] word_out;
        logic [159:0] image;
    } lvdtn_state_type;
endpackage

// *** tb/lvdtn_host_model.sv ***
// ----------------------------------------------------------------
// network host: command handshake on the transmit bit
// ----------------------------------------------------------------
module lvdtn_host_model
    import lvdtn_pkg::*;
(
    input wire logic clk,
    input wire logic [159:0] image_flat,
    output logic transmit
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle host keeps transmit low
    initial transmit = 1'b0;

    // one full handshake, ok low if the device never answers
    task automatic command(output logic ok);
        int n;
        ok = 1'b1;
        n = 0;
        @(posedge clk);
        transmit <= 1'b1;
        @(posedge clk);
        while (image_flat[LVDTN_BIT_ACK] !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) ok = 1'b0;
        // hold a while so a held transmit is seen as one command only
        repeat (3) @(posedge clk);
        transmit <= 1'b0;
        n = 0;
        while (image_flat[LVDTN_BIT_ACK] !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) ok = 1'b0;
    endtask
endmodule // lvdtn_host_model

// *** tb/lvdt_net_input_status_tb_top.sv ***
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL %0t got %h want %h", $time, (got), (exp)); end end
// ----------------------------------------------------------------
// bench for the network input image
// ----------------------------------------------------------------
module lvdt_net_input_status_tb_top
    import lvdtn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BEAT = 10; // short heartbeat for simulation
    localparam lvdtn_cmd_type ERR_IN [6] = '{'{1'b0, 1'b1, 1'b1, 16'h0320, 1'b1},
        '{1'b0, 1'b0, 1'b1, 16'h0320, 1'b1}, '{1'b0, 1'b0, 1'b0, 16'h031F, 1'b1},
        '{1'b0, 1'b0, 1'b0, 16'h2EE1, 1'b0}, '{1'b0, 1'b0, 1'b0, 16'h2EE0, 1'b1},
        '{1'b0, 1'b0, 1'b0, 16'h0320, 1'b0}};
    localparam logic [3:0] ERR_EXP [6] = '{LVDTN_ERR_CMD, LVDTN_ERR_FLASH,
        LVDTN_ERR_EXC_V, LVDTN_ERR_EXC_V, LVDTN_ERR_EXC_F, LVDTN_ERR_NONE};
    logic clk, arst_n, self_test_done, powered_up, is_slave, host_tx, cmd_accept, ok;
    lvdtn_mode_type mode;
    lvdtn_chan_type ch1, ch2;
    lvdtn_cmd_type cmd_f, cmd_bus;
    logic [3:0] rd_index;
    logic [15:0] rd_word, w;
    logic [159:0] image_flat;
    int n_fail = 0, comparisons = 0, n_acc = 0, acc0;

    // host owns transmit, bench owns the fault fields
    assign cmd_bus = '{host_tx, cmd_f.cmd_bad, cmd_f.flash_bad, cmd_f.exc_mv, cmd_f.exc_freq_bad};

    lvdtn_image #(.BEAT_CYCLES(BEAT)) dut_u (.clk(clk), .arst_n(arst_n),
        .self_test_done(self_test_done), .powered_up(powered_up), .mode(mode),
        .is_slave(is_slave), .ch1(ch1), .ch2(ch2), .cmd(cmd_bus), .rd_index(rd_index),
        .rd_word(rd_word), .image_flat(image_flat), .cmd_accept(cmd_accept));
    lvdtn_host_model host_u (.clk(clk), .image_flat(image_flat), .transmit(host_tx));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count accepted commands
    always @(posedge clk) if (cmd_accept === 1'b1) n_acc++;

    task automatic report_and_stop();
        $display("counts: %0d compares, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    // read one word through the index port, compare under a mask
    task automatic check_word(logic [3:0] idx, logic [15:0] exp, logic [15:0] msk);
        @(posedge clk);
        rd_index <= idx;
        repeat (2) @(posedge clk);
        #1 w = rd_word;
        `CHK(w & msk, exp)
    endtask
    task automatic check_chan(logic [3:0] b, logic [15:0] s, h, l, v);
        check_word(b, s, 16'hFFFF);
        check_word(b + 4'h1, h, 16'hFFFF);
        check_word(b + 4'h2, l, 16'hFFFF);
        check_word(b + 4'h3, v, 16'hFFFF);
    endtask
    // expected status word with acknowledge low, heartbeat masked off
    function automatic logic [15:0] exp_st(int m, logic s, logic i, logic [3:0] e);
        return {2'b00, s, i, 4'h8 >> m, 4'h0, e};
    endfunction
    // heartbeat half period in clocks
    task automatic beat_check();
        logic b;
        int n;
        @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            b = image_flat[LVDTN_BIT_BEAT];
            n = 0;
            while (image_flat[LVDTN_BIT_BEAT] === b && n < 40) begin
                @(posedge clk);
                n++;
            end
        end
        `CHK(n, BEAT)
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    // main sequence
    initial begin
        arst_n = 1'b0;
        self_test_done = 1'b0;
        powered_up = 1'b0;
        is_slave = 1'b0;
        mode = LVDTN_MODE_CFG;
        rd_index = 4'h0;
        cmd_f = ERR_IN[5];
        ch1 = '{1'b1, 16'h4000, 32'hFFFFFFFF, 32'h00010000, 16'h04D2};
        ch2 = '{1'b1, 16'h4001, 32'h00000007, 32'hFFFF0000, 16'h162E};
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        self_test_done <= 1'b1;
        settle();
        check_word(4'h0, exp_st(1, 1'b0, 1'b1, LVDTN_ERR_NONE), 16'hBFFF);
        check_chan(4'h1, 16'h4000, 16'h0000, 16'h0000, 16'h0000);
        check_chan(4'h5, 16'h4001, 16'h0000, 16'h0000, 16'h0000);
        $display("test power-up done");
        powered_up <= 1'b1;
        mode <= LVDTN_MODE_ALN;
        ch2.enabled <= 1'b0;
        settle();
        check_chan(4'h1, 16'h4000, 16'h8000, 16'h0001, 16'h0000);
        check_chan(4'h5, 16'h4001, 16'h0000, 16'h0000, 16'h0000);
        $display("test alignment done");
        mode <= LVDTN_MODE_MEAS;
        ch2.enabled <= 1'b1;
        settle();
        check_chan(4'h1, 16'h4000, 16'h0001, 16'h0000, 16'h04D2);
        check_chan(4'h5, 16'h4001, 16'h8001, 16'h0000, 16'h162E);
        check_word(4'h9, 16'h0000, 16'hFFFF);
        check_word(4'hA, 16'h0000, 16'hFFFF);
        $display("test measurement done");
        for (int m = 0; m < 4; m++) begin
            mode <= lvdtn_mode_type'(m[1:0]);
            is_slave <= m[0];
            settle();
            check_word(4'h0, exp_st(m, m[0], 1'b1, LVDTN_ERR_NONE), 16'hBFFF);
        end
        beat_check();
        $display("test modes done");
        mode <= LVDTN_MODE_MEAS;
        is_slave <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            cmd_f <= ERR_IN[i];
            settle();
            acc0 = n_acc;
            host_u.command(ok);
            `CHK(ok, 1'b1)
            `CHK(n_acc, acc0 + 1)
            check_word(4'h0, exp_st(3, 1'b0, 1'b0, ERR_EXP[i]), 16'hBFFF);
        end
        $display("test commands done");
        ch1.enabled <= 1'b0;
        ch2.enabled <= 1'b0;
        settle();
        check_chan(4'h1, 16'h4000, 16'h0000, 16'h0000, 16'h0000);
        check_chan(4'h5, 16'h4001, 16'h0000, 16'h0000, 16'h0000);
        $display("test disabled done");
        report_and_stop();
    end
endmodule // lvdt_net_input_status_tb_top
